/* File: core/rxpco_pkg.sv */
// Functional notes
// - output character and status only change after a rising edge of the selected interface clock, or a falling recovered-clock edge at half rate.
// - with the decoder on (HIGH or MID) the character output carries a decoded byte or special code.
// - with the decoder on the three status bits describe each received character.
// - with the decoder bypassed the character output carries the upper eight bits of the raw 10-bit character.
// - with the decoder bypassed status bits one and zero carry the two low bits of the raw character.
// - with the decoder bypassed status bit two is high while the output register holds a comma.
// - with parity enabled (not LOW) the parity output is odd parity over the character, aligned with it.
// - with parity LOW the parity output is not driven and reads low; parity is still generated and stored with the character.
// - a ternary select left unconnected reads as MID.
// - with clock source LOW the output register is clocked from the reference clock.
// - with clock source MID the output register uses the recovered clock, which is also presented out.
package rxpco_pkg;

  // ----------------------------------------------------------------
  // ternary select pins
  // ----------------------------------------------------------------
  localparam logic [1:0] TERN_LOW = 2'h0;
  localparam logic [1:0] TERN_MID = 2'h1;
  localparam logic [1:0] TERN_HIGH = 2'h2;
  localparam logic [1:0] TERN_OPEN = 2'h3;
  // cycles after reset before synchronised select levels are trusted
  localparam logic [2:0] SETTLE_CYCLES = 3'h5;

  // ----------------------------------------------------------------
  // character layout
  // ----------------------------------------------------------------
  localparam int CHAR_W = 8;
  localparam int STAT_W = 3;
  localparam int RAW_W = 10;
  localparam int RAW_LO_W = 2;
  localparam int STAT_COMMA_BIT = 2;
  localparam int COMMA_W = 7;
  localparam logic [6:0] COMMA_POS = 7'h1F;
  localparam logic [6:0] COMMA_NEG = 7'h60;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_CLEAR = 5'h08;
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h0C;
  localparam logic [4:0] REG_LAST_CHAR = 5'h10;
  localparam logic [4:0] REG_CHAR_COUNT = 5'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RESET = 1'h1;
  localparam int EV_W = 4;
  localparam int EV_LOAD = 0;
  localparam int EV_COMMA = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_CFG_ERR = 3;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // one presented character
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CHAR_W-1:0] data;
    logic [STAT_W-1:0] status;
    logic parity;
  } rxpco_char_s;

  // unconnected reads as mid
  function automatic logic [1:0] tern_level(input logic [1:0] pin);
    tern_level = (pin == TERN_OPEN) ? TERN_MID : pin;
  endfunction : tern_level

  function automatic logic odd_parity(input logic [CHAR_W-1:0] d);
    odd_parity = ~^d;
  endfunction : odd_parity

  function automatic logic is_comma(input logic [RAW_W-1:0] raw);
    is_comma = (raw[RAW_W-1 -: COMMA_W] == COMMA_POS) || (raw[RAW_W-1 -: COMMA_W] == COMMA_NEG);
  endfunction : is_comma

endpackage : rxpco_pkg

/* File: core/rxpco_sync.sv */
`timescale 1ns/100ps
module rxpco_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] ff1_q, ff2_q, ff3_q, lvl_q;
  logic [WIDTH-1:0] lvl_d;

  // ----------------------------------------------------------------
  // accept a change only when second and third stage agree
  // ----------------------------------------------------------------
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (ff2_q[i] == ff3_q[i]) begin
        lvl_d[i] = ff3_q[i];
      end
    end
  end

  // three stages; ff1 only feeds ff2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
      lvl_q <= '0;
    end else begin
      ff1_q <= pin;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;

endmodule : rxpco_sync

/* File: core/rxpco_top.sv */
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
module rxpco_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [rxpco_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic dec_valid,
  input wire logic [rxpco_pkg::CHAR_W-1:0] dec_char,
  input wire logic [rxpco_pkg::STAT_W-1:0] dec_status,
  input wire logic [rxpco_pkg::RAW_W-1:0] raw_char,
  input wire logic reference_clock_in,
  input wire logic recovered_clock_in,
  input wire logic [1:0] decoder_mode_sel,
  input wire logic [1:0] parity_ctrl_sel,
  input wire logic [1:0] rx_clock_source_sel,
  input wire logic [1:0] rx_clock_rate_sel,
  output logic [rxpco_pkg::CHAR_W-1:0] rx_char_out,
  output logic [rxpco_pkg::STAT_W-1:0] rx_status_out,
  output logic rx_parity_out,
  output logic rx_parity_oe,
  output logic rx_interface_clock
);

  // ----------------------------------------------------------------
  // pin synchronisers: clocks in bits 1:0, ternary selects above
  // ----------------------------------------------------------------
  logic [9:0] pin_lvl, pin_rise, pin_fall;
  logic [1:0] dec_lv, par_lv, src_lv, rate_lv;
  logic ref_rise, rec_rise, rec_fall, out_en;

  rxpco_sync #(.WIDTH(10)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin({rx_clock_rate_sel, rx_clock_source_sel, parity_ctrl_sel, decoder_mode_sel,
          recovered_clock_in, reference_clock_in}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign dec_lv = rxpco_pkg::tern_level(pin_lvl[3:2]);
  assign par_lv = rxpco_pkg::tern_level(pin_lvl[5:4]);
  assign src_lv = rxpco_pkg::tern_level(pin_lvl[7:6]);
  assign rate_lv = rxpco_pkg::tern_level(pin_lvl[9:8]);
  assign ref_rise = pin_rise[0];
  assign rec_rise = pin_rise[1];
  assign rec_fall = pin_fall[1];

  // recovered clock otherwise; half rate also uses the complement edge
  assign out_en = (src_lv == rxpco_pkg::TERN_LOW) ? ref_rise
                : (rec_rise || (rate_lv == rxpco_pkg::TERN_HIGH && rec_fall));
  // interface clock follows the selected source
  assign rx_interface_clock = (src_lv == rxpco_pkg::TERN_LOW) ? pin_lvl[0] : pin_lvl[1];

  // ----------------------------------------------------------------
  // settle timer after reset
  // ----------------------------------------------------------------
  // select levels read LOW until the pins have crossed the synchroniser;
  // only the misconfiguration event waits, the data path does not
  logic [2:0] settle_q, settle_d;
  logic cfg_ok;

  assign cfg_ok = (settle_q == rxpco_pkg::SETTLE_CYCLES);

  // count up once after reset, then hold
  always_comb begin
    settle_d = settle_q;
    if (!cfg_ok) begin
      settle_d = settle_q + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= '0;
    end else begin
      settle_q <= settle_d;
    end
  end

  // ----------------------------------------------------------------
  // character holding and output registers
  // ----------------------------------------------------------------
  rxpco_pkg::rxpco_char_s hold_q, hold_d, out_q, out_d, fmt;
  logic hold_full_q, hold_full_d, ctrl_en_q;
  logic load, take, overrun, comma_ev;

  // format at capture so a later mode change cannot split a character
  always_comb begin
    fmt = '0;
    if (dec_lv == rxpco_pkg::TERN_LOW) begin
      fmt.data = raw_char[rxpco_pkg::RAW_W-1 -: rxpco_pkg::CHAR_W];
      fmt.status[rxpco_pkg::RAW_LO_W-1:0] = raw_char[rxpco_pkg::RAW_LO_W-1:0];
      fmt.status[rxpco_pkg::STAT_COMMA_BIT] = rxpco_pkg::is_comma(raw_char);
    end else begin
      fmt.data = dec_char;
      fmt.status = dec_status;
    end
    fmt.parity = rxpco_pkg::odd_parity(fmt.data);
  end

  assign take = dec_valid && ctrl_en_q;
  assign load = out_en && hold_full_q;
  // a second character before the interface edge replaces the first
  assign overrun = take && hold_full_q && !load;

  // output register moves as a whole on the selected edge only
  always_comb begin
    hold_d = hold_q;
    hold_full_d = hold_full_q;
    out_d = out_q;
    if (load) begin
      out_d = hold_q;
      hold_full_d = 1'b0;
    end
    if (take) begin
      hold_d = fmt;
      hold_full_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
      hold_full_q <= 1'b0;
      out_q <= '{data: '0, status: '0, parity: 1'b1};
    end else begin
      hold_q <= hold_d;
      hold_full_q <= hold_full_d;
      out_q <= out_d;
    end
  end

  assign rx_char_out = out_q.data;
  assign rx_status_out = out_q.status;
  assign rx_parity_oe = (par_lv != rxpco_pkg::TERN_LOW);
  assign rx_parity_out = rx_parity_oe && out_q.parity;
  assign comma_ev = load && (dec_lv == rxpco_pkg::TERN_LOW)
                  && hold_q.status[rxpco_pkg::STAT_COMMA_BIT];

  // ----------------------------------------------------------------
  // avalon slave and interrupt registers
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [rxpco_pkg::EV_W-1:0] ev_stat_q, ev_stat_d, ev_en_q, ev_en_d, ev_set;
  logic ctrl_en_d;
  logic [rxpco_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic wr_hit, rd_hit;

  // waitrequest is combinational: every access answers one cycle after it rises,
  // so a master never sees more than a single wait state
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_hit = avs_write && ack_q && avs_byteenable[0];
  assign rd_hit = avs_read && !ack_q;
  // decoder bypass with any clock source other than MID is a misconfiguration
  assign ev_set[rxpco_pkg::EV_CFG_ERR] = cfg_ok && (dec_lv == rxpco_pkg::TERN_LOW)
                                       && (src_lv != rxpco_pkg::TERN_MID);
  assign ev_set[rxpco_pkg::EV_LOAD] = load;
  assign ev_set[rxpco_pkg::EV_COMMA] = comma_ev;
  assign ev_set[rxpco_pkg::EV_OVERRUN] = overrun;

  // one wait cycle per access; set beats clear on the status bits
  always_comb begin
    ack_d = (avs_read || avs_write) && !ack_q;
    ctrl_en_d = ctrl_en_q;
    ev_en_d = ev_en_q;
    ev_stat_d = ev_stat_q;
    cnt_d = load ? cnt_q + 1'b1 : cnt_q;
    rdata_d = rdata_q;
    if (wr_hit) begin
      case (avs_address)
        rxpco_pkg::REG_CTRL: ctrl_en_d = avs_writedata[rxpco_pkg::CTRL_EN_BIT];
        rxpco_pkg::REG_IRQ_CLEAR: ev_stat_d = ev_stat_q & ~avs_writedata[rxpco_pkg::EV_W-1:0];
        rxpco_pkg::REG_IRQ_ENABLE: ev_en_d = avs_writedata[rxpco_pkg::EV_W-1:0];
        default: ctrl_en_d = ctrl_en_q;
      endcase
    end
    ev_stat_d = ev_stat_d | ev_set;
    if (rd_hit) begin
      case (avs_address)
        rxpco_pkg::REG_CTRL: rdata_d = {31'h0, ctrl_en_q};
        rxpco_pkg::REG_IRQ_STATUS: rdata_d = {28'h0, ev_stat_q};
        rxpco_pkg::REG_IRQ_ENABLE: rdata_d = {28'h0, ev_en_q};
        rxpco_pkg::REG_LAST_CHAR: rdata_d = {20'h0, out_q};
        rxpco_pkg::REG_CHAR_COUNT: rdata_d = {16'h0, cnt_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      ctrl_en_q <= rxpco_pkg::CTRL_RESET;
      ev_en_q <= '0;
      ev_stat_q <= '0;
      cnt_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      ctrl_en_q <= ctrl_en_d;
      ev_en_q <= ev_en_d;
      ev_stat_q <= ev_stat_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign irq = |(ev_stat_q & ev_en_q);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // pin edges reach out_en three cycles after they are first sampled
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_out_on_edge: assert property ($changed(out_q) |-> $past(out_en))
    else $error("output changed without interface edge");
  a_dec_char: assert property (take && dec_lv != rxpco_pkg::TERN_LOW |=>
    hold_q.data == $past(dec_char)) else $error("decoded byte not captured");
  a_dec_status: assert property (take && dec_lv != rxpco_pkg::TERN_LOW |=>
    hold_q.status == $past(dec_status)) else $error("decoder status not captured");
  a_raw_upper: assert property (take && dec_lv == rxpco_pkg::TERN_LOW |=>
    hold_q.data == $past(raw_char[9:2])) else $error("raw upper bits wrong");
  a_raw_lower: assert property (take && dec_lv == rxpco_pkg::TERN_LOW |=>
    hold_q.status[1:0] == $past(raw_char[1:0])) else $error("raw low bits wrong");
  a_comma_flag: assert property (load && dec_lv == rxpco_pkg::TERN_LOW |=>
    rx_status_out[2] == rxpco_pkg::is_comma({rx_char_out, rx_status_out[1:0]}))
    else $error("comma flag wrong");
  a_par_odd: assert property (rx_parity_oe |-> ^{rx_char_out, rx_parity_out})
    else $error("parity not odd");
  a_par_off: assert property ((parity_ctrl_sel == rxpco_pkg::TERN_LOW) [*6] |->
    !rx_parity_oe && !rx_parity_out) else $error("parity driven while disabled");
  a_open_mid: assert property (decoder_mode_sel == rxpco_pkg::TERN_OPEN [*6] |->
    dec_lv == rxpco_pkg::TERN_MID) else $error("open select not mid");
  a_ref_clock: assert property ($rose(reference_clock_in) &&
    src_lv == rxpco_pkg::TERN_LOW ##3 src_lv == rxpco_pkg::TERN_LOW |-> out_en)
    else $error("reference clock not selected");
  a_rec_clock: assert property ($rose(recovered_clock_in) &&
    src_lv != rxpco_pkg::TERN_LOW ##3 src_lv != rxpco_pkg::TERN_LOW |->
    out_en && !rx_interface_clock) else $error("recovered clock not selected");
  a_half_rate: assert property ($fell(recovered_clock_in) &&
    rate_lv == rxpco_pkg::TERN_HIGH && src_lv != rxpco_pkg::TERN_LOW ##3
    rate_lv == rxpco_pkg::TERN_HIGH && src_lv != rxpco_pkg::TERN_LOW |-> out_en)
    else $error("half rate edge missed");
  a_char_whole: assert property (load |=> out_q == $past(hold_q))
    else $error("character fields split");
  // one wait state per read access
  a_wait_one: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait");
  // read data stands after the answer
  a_rdata_stand: assert property (avs_read && !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data moved after answer");
  // set beats clear on every status bit
  a_set_wins: assert property (|ev_set |=> (ev_stat_q & $past(ev_set)) == $past(ev_set))
    else $error("status event lost");
  // characters refused while capture is off
  a_cap_gated: assert property (dec_valid && !ctrl_en_q |=> $stable(hold_q))
    else $error("character taken while disabled");
  // count moves by one per load
  a_count_step: assert property (load |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("load count wrong");
  // a clear write empties the bits it names
  a_clear_acts: assert property (wr_hit && avs_address == rxpco_pkg::REG_IRQ_CLEAR
    && !(|ev_set) |=> (ev_stat_q & $past(avs_writedata[rxpco_pkg::EV_W-1:0])) == '0)
    else $error("clear write ignored");

  c_dec_load: cover property (load && dec_lv != rxpco_pkg::TERN_LOW);
  c_raw_comma: cover property (comma_ev);
  c_overrun: cover property (overrun);
  c_irq: cover property ($rose(irq));
  c_half_rate: cover property (load && rec_fall && rate_lv == rxpco_pkg::TERN_HIGH);

endmodule : rxpco_top

/* File: tb/rxpco_host_model.sv */
`timescale 1ns/100ps
// --------------------------------------------------------------
// host capture register fed by the interface clock
// --------------------------------------------------------------
module rxpco_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_interface_clock,
  input wire logic [1:0] rx_clock_rate_sel,
  input wire logic [rxpco_pkg::CHAR_W-1:0] rx_char_out,
  input wire logic [rxpco_pkg::STAT_W-1:0] rx_status_out,
  input wire logic rx_parity_out,
  output rxpco_pkg::rxpco_char_s cap,
  output logic cap_pulse
);
  logic clk_q;
  logic [1:0] dly_q;
  logic edge_seen;

  assign edge_seen = (rx_interface_clock & ~clk_q) |
                     ((rx_clock_rate_sel == rxpco_pkg::TERN_HIGH) & clk_q & ~rx_interface_clock);

  // capture lags two cycles so the outputs have settled after the edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_q <= 1'b0;
      dly_q <= 2'h0;
      cap_pulse <= 1'b0;
      cap <= '0;
    end else begin
      clk_q <= rx_interface_clock;
      dly_q <= {dly_q[0], edge_seen};
      cap_pulse <= dly_q[1];
      if (dly_q[1]) begin
        cap <= {rx_char_out, rx_status_out, rx_parity_out};
      end
    end
  end
endmodule : rxpco_host_model

/* File: tb/test_rx_parallel_char_output.sv */
`timescale 1ns/100ps
module test_rx_parallel_char_output;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, irq, dec_valid;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0] avs_byteenable;
  logic [7:0] dec_char, rx_char_out;
  logic [2:0] dec_status, rx_status_out;
  logic [9:0] raw_char;
  logic reference_clock_in, recovered_clock_in, rx_parity_out, rx_parity_oe, rx_interface_clock;
  logic [1:0] decoder_mode_sel, parity_ctrl_sel, rx_clock_source_sel, rx_clock_rate_sel;
  logic cap_pulse, oe;
  rxpco_pkg::rxpco_char_s cap, e;
  rxpco_pkg::rxpco_char_s exp_q[$];
  int errors, total_checks, loads, n;

  rxpco_top dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .dec_valid(dec_valid), .dec_char(dec_char), .dec_status(dec_status), .raw_char(raw_char),
    .reference_clock_in(reference_clock_in), .recovered_clock_in(recovered_clock_in),
    .decoder_mode_sel(decoder_mode_sel), .parity_ctrl_sel(parity_ctrl_sel),
    .rx_clock_source_sel(rx_clock_source_sel), .rx_clock_rate_sel(rx_clock_rate_sel),
    .rx_char_out(rx_char_out), .rx_status_out(rx_status_out), .rx_parity_out(rx_parity_out),
    .rx_parity_oe(rx_parity_oe), .rx_interface_clock(rx_interface_clock));

  rxpco_host_model host (.clk(clk), .rst_b(rst_b), .rx_interface_clock(rx_interface_clock),
    .rx_clock_rate_sel(rx_clock_rate_sel), .rx_char_out(rx_char_out),
    .rx_status_out(rx_status_out), .rx_parity_out(rx_parity_out), .cap(cap),
    .cap_pulse(cap_pulse));

  // --------------------------------------------------------------
  // clocks: link clocks unrelated in phase to the system clock
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    reference_clock_in = 1'b0;
    // offset keeps pin edges off the sampling edge of clk
    #1.3;
    forever #62.5 reference_clock_in = ~reference_clock_in;
  end
  // recovered clock runs continuously, as the device presents it
  initial begin
    recovered_clock_in = 1'b0;
    #37.3;
    forever #62.5 recovered_clock_in = ~recovered_clock_in;
  end

  // --------------------------------------------------------------
  // checking and closing
  // --------------------------------------------------------------
  task automatic chk_reg(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_reg

  task automatic chk_char(input string nm, input rxpco_pkg::rxpco_char_s ex,
                          input rxpco_pkg::rxpco_char_s got);
    total_checks++;
    if (got !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_char

  task automatic stop_test;
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // watchdog sized well beyond the expected run of roughly a thousand cycles
  initial begin
    #200us;
    errors++;
    stop_test;
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {rst_b, avs_read, avs_write, dec_valid, avs_address, avs_writedata} = '0;
    {dec_char, dec_status, raw_char} = '0;
    avs_byteenable = 4'hF;
    {decoder_mode_sel, parity_ctrl_sel, rx_clock_rate_sel} = 6'h15;
    rx_clock_source_sel = rxpco_pkg::TERN_MID;
    errors = 0;
    total_checks = 0;
    loads = 0;
    void'($urandom(93));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk_char("reset outputs", 12'h001, {rx_char_out, rx_status_out, rx_parity_out});
    bus(1'b0, rxpco_pkg::REG_CTRL, 32'h0, 4'hF, d);
    chk_reg("ctrl reset", 32'h1, d);
    // byte lane 0 off: write ignored; unmapped place reads zero
    bus(1'b1, rxpco_pkg::REG_IRQ_ENABLE, 32'h1, 4'h0, d);
    bus(1'b0, rxpco_pkg::REG_IRQ_ENABLE, 32'h0, 4'hF, d);
    chk_reg("enable masked write", 32'h0, d);
    bus(1'b1, 5'h18, 32'hFFFFFFFF, 4'hF, d);
    bus(1'b0, 5'h18, 32'h0, 4'hF, d);
    chk_reg("unmapped read", 32'h0, d);
    bus(1'b1, rxpco_pkg::REG_IRQ_ENABLE, 32'h1, 4'hF, d);
    for (int i = 0; i < 24; i++) begin
      // every decoder and parity code, open included; source only mid or low, kept mid while bypassed
      decoder_mode_sel <= 2'(i % 4);
      parity_ctrl_sel <= 2'((i / 4) % 4);
      rx_clock_source_sel <= ((i % 4) == 0 || (i % 3) != 0) ? rxpco_pkg::TERN_MID : 2'h0;
      rx_clock_rate_sel <= 2'($urandom_range(0, 3));
      if (i == 23) bus(1'b1, rxpco_pkg::REG_IRQ_ENABLE, 32'h0, 4'hF, d);
      repeat (8) @(posedge clk);
      dec_char <= 8'($urandom);
      dec_status <= 3'($urandom);
      raw_char <= (i % 5 == 0) ? {7'h1F, 3'($urandom)} :
                  (i % 5 == 1) ? {7'h60, 3'($urandom)} : 10'($urandom);
      dec_valid <= 1'b1;
      @(posedge clk);
      dec_valid <= 1'b0;
      // reference model of the formatted character
      oe = (parity_ctrl_sel != rxpco_pkg::TERN_LOW);
      e.data = (decoder_mode_sel == 2'h0) ? raw_char[9:2] : dec_char;
      e.status = (decoder_mode_sel == 2'h0) ?
        {(raw_char[9:3] == 7'h1F) || (raw_char[9:3] == 7'h60), raw_char[1:0]} : dec_status;
      e.parity = oe & ~^e.data;
      exp_q.push_back(e);
      loads++;
      n = 0;
      do begin
        bus(1'b0, rxpco_pkg::REG_IRQ_STATUS, 32'h0, 4'hF, d);
        n++;
      end while (d[0] !== 1'b1 && n < 100);
      if (n >= 100) errors++;
      @(negedge clk);
      e = exp_q.pop_front();
      chk_char("char outputs", e, {rx_char_out, rx_status_out, rx_parity_out});
      chk_reg("parity enable", 32'(oe), 32'(rx_parity_oe));
      chk_reg("irq level", 32'(i != 23), 32'(irq));
      if (i == 23) begin
        bus(1'b1, rxpco_pkg::REG_IRQ_ENABLE, 32'h1, 4'hF, d);
        @(negedge clk);
        chk_reg("irq unmasked", 32'h1, 32'(irq));
      end
      n = 0;
      while (cap_pulse !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      if (n >= 100) errors++;
      chk_char("host capture", e, cap);
      bus(1'b0, rxpco_pkg::REG_LAST_CHAR, 32'h0, 4'hF, d);
      // stored parity bit is always computed, even with the pin off
      chk_reg("last char", {20'h0, e.data, e.status, ~^e.data}, d);
      bus(1'b1, rxpco_pkg::REG_IRQ_CLEAR, 32'h1, 4'hF, d);
      @(negedge clk);
      chk_reg("irq cleared", 32'h0, 32'(irq));
    end
    // capture disabled: a character pulse must be refused
    bus(1'b1, rxpco_pkg::REG_CTRL, 32'h0, 4'hF, d);
    bus(1'b0, rxpco_pkg::REG_CTRL, 32'h0, 4'hF, d);
    chk_reg("ctrl written", 32'h0, d);
    dec_char <= 8'($urandom);
    dec_valid <= 1'b1;
    @(posedge clk);
    dec_valid <= 1'b0;
    repeat (40) @(posedge clk);
    bus(1'b0, rxpco_pkg::REG_CHAR_COUNT, 32'h0, 4'hF, d);
    chk_reg("char count", 32'(loads), d);
    stop_test;
  end
endmodule : test_rx_parallel_char_output
